// ===== verilog/uart_frame_pkg.sv
/*
 Shared constants and carrier types for the serial frame control block.
 Assumes a 200 MHz system clock and a plain strobe register port.
*/
package uart_frame_pkg;
	// ----------------------------------------
	// Register map (byte address)
	// ----------------------------------------
	localparam logic [3:0] ADDR_FRAME_CTRL = 4'h0;
	localparam logic [3:0] ADDR_STATUS = 4'h4;
	localparam logic [3:0] ADDR_SECOND_CTRL = 4'h8;
	localparam logic [3:0] ADDR_TX_HOLD = 4'hC;
	// Receive data and divisor sit on odd bytes of their own
	localparam logic [3:0] ADDR_RX_DATA = 4'h1;
	localparam logic [3:0] ADDR_BAUD = 4'h5;

	// ----------------------------------------
	// Frame control field positions
	// ----------------------------------------
	localparam int FC_GLOBAL_EN = 7;
	localparam int FC_NINE_BIT = 6;
	localparam int FC_PARITY_EN = 5;
	localparam int FC_ODD_PARITY = 4;
	localparam int FC_TWO_STOP = 3;
	localparam int FC_BREAK = 2;
	localparam int FC_RX_NINTH = 1;
	localparam int FC_TX_NINTH = 0;

	// ----------------------------------------
	// Second control and status positions
	// ----------------------------------------
	localparam int SC_TX_EN = 7;
	localparam int SC_RX_EN = 6;
	localparam int ST_PARITY_ERR = 7;
	localparam int ST_NOISE = 6;
	localparam int ST_FRAMING = 5;
	localparam int ST_OVERRUN = 4;
	localparam int ST_RX_IDLE = 3;
	localparam int ST_RX_AVAIL = 2;
	localparam int ST_TX_IDLE = 1;
	localparam int ST_TX_EMPTY = 0;

	// ----------------------------------------
	// Reset values and timing counts
	// ----------------------------------------
	localparam logic [7:0] FRAME_CTRL_RST = 8'h00;
	localparam logic [7:0] SECOND_CTRL_RST = 8'h00;
	localparam logic [7:0] BAUD_RST = 8'h0F;
	localparam logic [3:0] BREAK_MIN_BITS = 4'hD;

	// Transmitter states
	typedef enum logic [2:0]
	{
		TX_IDLE = 3'b000,
		TX_START = 3'b001,
		TX_DATA = 3'b010,
		TX_PAR = 3'b011,
		TX_STOP = 3'b100,
		TX_BRK = 3'b101
	} tx_state_e;

	// Frame settings shared with the transmitter
	typedef struct packed
	{
		logic nine_bit_select;
		logic parity_enable;
		logic odd_parity_select;
		logic two_stop_select;
		logic break_request;
	} frame_cfg_s;
endpackage

// ===== verilog/baud_tick_gen.sv
/*
 Baud tick generator: one pulse each divisor+1 clocks.
 Assumes clear is held while the serial unit is disabled.
*/
module baud_tick_gen
	import uart_frame_pkg::*;
#(
	parameter int W = 8
)
(
	input wire logic clk, // System clock
	input wire logic rst_b, // Async reset, low
	input wire logic clear, // Reload counter
	input wire logic [W-1:0] divisor, // Bit period minus one
	output logic tick // One bit period elapsed
);
	typedef struct packed
	{
		logic [W-1:0] cnt;
		logic tick;
	} st_s;
	st_s st_r;
	st_s st_nxt;

	// ----------------------------------------
	// Counter
	// ----------------------------------------
	// Count down, reload at zero or on clear
	always_comb
	begin
		st_nxt = st_r;
		st_nxt.tick = 1'b0;
		if (clear)
			st_nxt.cnt = divisor; // R05
		else if (st_r.cnt == '0)
		begin
			st_nxt.cnt = divisor;
			st_nxt.tick = 1'b1;
		end
		else
			st_nxt.cnt = st_r.cnt - 1'b1;
	end

	// State register
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end

	assign tick = st_r.tick;
endmodule

// ===== verilog/rx_pin_sync.sv
/*
 Three-stage synchroniser for the receive pin.
 A change counts once the second and third stages agree.
*/
module rx_pin_sync
	import uart_frame_pkg::*;
(
	input wire logic clk, // System clock
	input wire logic rst_b, // Async reset, low
	input wire logic pin_in, // Raw pin level
	output logic level // Filtered level
);
	typedef struct packed
	{
		logic [2:0] sh;
		logic level;
	} st_s;
	st_s st_r;
	st_s st_nxt;

	// Shift and agree
	always_comb
	begin
		st_nxt = st_r;
		st_nxt.sh = {st_r.sh[1:0], pin_in};
		if (st_r.sh[1] == st_r.sh[2])
			st_nxt.level = st_r.sh[2];
	end

	// State register, idle high
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			st_r <= '1;
		else
			st_r <= st_nxt;
	end

	assign level = st_r.level;
endmodule

// ===== verilog/uart_frame_control.sv
/*
 Serial frame control and transmitter with a simple receiver.
 Assumes a strobe register port with read data one cycle later,
 and a pin mux outside that honours the enable outputs.
*/
// Function
// R01 - Empty flag sets when holding moves to shifter
// R02 - Status read then holding write clears empty
// R03 - Enabling transmitter sets empty flag
// R04 - Global enable hands pins to serial unit; code also needs the transmit or receive enable for each pin
// R05 - Disable flushes buffers, reloads baud counter
// R06 - Disable clears enables/flags, sets idle flags
// R07 - Disable keeps other configuration bits
// R08 - Disable aborts active transfers at once
// R09 - Length bit picks 8 or 9 bits
// R10 - Nine-bit parity not stored in ninth bit
// R11 - Eight-bit parity not stored in bit seven
// R12 - Parity enable turns parity on
// R13 - Parity type: odd when set
// R14 - Stop select gives one or two two_stop_select
// R15 - Break after data, low thirteen bits minimum
// R16 - Read-only ninth received bit
// R17 - Write-only ninth transmit bit, resets zero
// R18 - Idle when empty and nothing sending
// R19 - Transmitter runs with both enables set
// R20 - Start low, LSB first, parity, two_stop_select
module uart_frame_control
	import uart_frame_pkg::*;
#(
	parameter int DIV_W = 8
)
(
	input wire logic clk, // 200 MHz clock
	input wire logic rst_b, // Async reset, low
	input wire logic [3:0] addr, // Register byte address
	input wire logic [7:0] wdata, // Write data
	input wire logic wr, // Write strobe
	input wire logic rd, // Read strobe
	output logic [7:0] rdata, // Read data, next cycle
	input wire logic rx_pin, // Serial receive pin
	output logic tx_out, // Serial transmit level
	output logic tx_oe, // Unit owns transmit pin
	output logic rx_own // Unit owns receive pin
);
	typedef struct packed
	{
		logic [7:0] fc;
		logic [7:0] sc;
		logic [DIV_W-1:0] baud;
		logic [8:0] hold;
		logic hold_full;
		logic [8:0] shift;
		logic [3:0] cnt;
		logic stop2;
		logic par;
		tx_state_e txs;
		logic tx_line;
		logic tx_empty;
		logic tx_idle;
		logic empty_seen;
		logic idle_seen;
		logic [7:0] rxd;
		logic rx_avail;
		logic rx_idle;
		logic rx_busy;
		logic [3:0] rcnt;
		logic [8:0] rsh;
		logic [7:0] rdata;
	} st_s;
	st_s st_r;
	st_s st_nxt;

	logic tick;
	logic rx_level;
	logic global_en;
	logic disable_now;
	frame_cfg_s cfg;
	logic [3:0] nbits;

	assign global_en = st_r.fc[FC_GLOBAL_EN];
	assign cfg = {st_r.fc[FC_NINE_BIT], st_r.fc[FC_PARITY_EN],
		st_r.fc[FC_ODD_PARITY], st_r.fc[FC_TWO_STOP], st_r.fc[FC_BREAK]};
	assign disable_now = !global_en;
	// Bits between start and stop, parity slot included: 8 or 9
	assign nbits = cfg.nine_bit_select ? 4'h9 : 4'h8; // R09

	baud_tick_gen #(.W(DIV_W)) u_baud
	(
		.clk(clk),
		.rst_b(rst_b),
		.clear(disable_now), // R05
		.divisor(st_r.baud),
		.tick(tick)
	);

	rx_pin_sync u_rxs
	(
		.clk(clk),
		.rst_b(rst_b),
		.pin_in(rx_pin),
		.level(rx_level)
	);

	// ----------------------------------------
	// Next-state logic
	// ----------------------------------------
	always_comb
	begin
		logic tx_run;
		logic [8:0] word;
		tx_run = 1'b0;
		word = '0;
		st_nxt = st_r;
		tx_run = global_en && st_r.sc[SC_TX_EN]; // R19
		// Register reads, status read arms the clears
		if (rd)
		begin
			case (addr)
				ADDR_FRAME_CTRL: st_nxt.rdata = {st_r.fc[7:1], 1'b0}; // R17
				ADDR_STATUS:
				begin
					st_nxt.rdata = 8'h00;
					st_nxt.rdata[ST_TX_EMPTY] = st_r.tx_empty;
					st_nxt.rdata[ST_TX_IDLE] = st_r.tx_idle;
					st_nxt.rdata[ST_RX_AVAIL] = st_r.rx_avail;
					st_nxt.rdata[ST_RX_IDLE] = st_r.rx_idle;
					st_nxt.empty_seen = st_r.tx_empty; // R02
					st_nxt.idle_seen = st_r.tx_idle;
				end
				ADDR_SECOND_CTRL: st_nxt.rdata = st_r.sc;
				ADDR_RX_DATA:
				begin
					st_nxt.rdata = st_r.rxd;
					st_nxt.rx_avail = 1'b0;
				end
				ADDR_BAUD: st_nxt.rdata = 8'(st_r.baud);
				default: st_nxt.rdata = 8'h00;
			endcase
		end
		// Register writes
		if (wr)
		begin
			case (addr)
				ADDR_FRAME_CTRL:
				begin
					st_nxt.fc = {wdata[7:2], st_r.fc[FC_RX_NINTH], wdata[0]};
				end
				ADDR_SECOND_CTRL:
				begin
					st_nxt.sc = wdata;
					if (wdata[SC_TX_EN] && !st_r.sc[SC_TX_EN]
						&& !st_r.hold_full)
						st_nxt.tx_empty = 1'b1; // R03
				end
				ADDR_BAUD: st_nxt.baud = DIV_W'(wdata);
				ADDR_TX_HOLD:
				begin
					st_nxt.hold = {st_r.fc[FC_TX_NINTH], wdata}; // R17
					st_nxt.hold_full = 1'b1;
					if (st_r.empty_seen)
					begin
						st_nxt.tx_empty = 1'b0; // R02
						st_nxt.empty_seen = 1'b0;
					end
					if (st_r.idle_seen)
					begin
						st_nxt.tx_idle = 1'b0;
						st_nxt.idle_seen = 1'b0;
					end
				end
				default: ;
			endcase
		end
		// Transmitter
		if (!tx_run)
		begin
			st_nxt.txs = TX_IDLE; // R08
			st_nxt.tx_line = 1'b1;
		end
		else
		begin
			case (st_r.txs)
				TX_IDLE:
				begin
					if (tick && st_r.hold_full)
					begin
						st_nxt.shift = st_r.hold;
						st_nxt.hold_full = 1'b0;
						st_nxt.tx_empty = 1'b1; // R01
						st_nxt.tx_idle = 1'b0;
						st_nxt.par = cfg.odd_parity_select; // R13
						st_nxt.cnt = 4'h0;
						st_nxt.stop2 = cfg.two_stop_select; // R14
						st_nxt.tx_line = 1'b0; // R20
						st_nxt.txs = TX_START;
					end
					else if (tick && cfg.break_request)
					begin
						st_nxt.tx_idle = 1'b0;
						st_nxt.tx_line = 1'b0; // R15
						st_nxt.cnt = 4'h0;
						st_nxt.txs = TX_BRK;
					end
					else if (st_r.tx_empty)
						st_nxt.tx_idle = 1'b1; // R18
				end
				TX_START, TX_DATA:
				begin
					if (tick)
					begin
						if (st_r.cnt == nbits - 4'h1 && cfg.parity_enable)
						begin
							// Last slot carries parity instead of data
							st_nxt.tx_line = st_r.par; // R10 R11 R12
							st_nxt.txs = TX_PAR;
						end
						else if (st_r.cnt == nbits)
						begin
							st_nxt.tx_line = 1'b1;
							st_nxt.txs = TX_STOP;
						end
						else
						begin
							st_nxt.tx_line = st_r.shift[0]; // R20
							st_nxt.par = st_r.par ^ st_r.shift[0];
							st_nxt.shift = {1'b0, st_r.shift[8:1]};
							st_nxt.cnt = st_r.cnt + 4'h1;
							st_nxt.txs = TX_DATA;
						end
					end
				end
				TX_PAR:
				begin
					if (tick)
					begin
						st_nxt.tx_line = 1'b1;
						st_nxt.txs = TX_STOP;
					end
				end
				TX_STOP:
				begin
					if (tick)
					begin
						if (st_r.stop2)
							st_nxt.stop2 = 1'b0; // R14
						else
							st_nxt.txs = TX_IDLE;
					end
				end
				TX_BRK:
				begin
					if (tick && st_r.cnt != BREAK_MIN_BITS)
						st_nxt.cnt = st_r.cnt + 4'h1;
					if (tick && st_r.cnt == BREAK_MIN_BITS
						&& !cfg.break_request)
					begin
						st_nxt.tx_line = 1'b1; // R15
						st_nxt.txs = TX_IDLE;
					end
				end
				default: st_nxt.txs = TX_IDLE;
			endcase
		end
		// Receiver: sample once per bit period
		if (!(global_en && st_r.sc[SC_RX_EN]))
		begin
			st_nxt.rx_busy = 1'b0;
			st_nxt.rx_idle = 1'b1;
		end
		else if (tick)
		begin
			if (!st_r.rx_busy)
			begin
				if (!rx_level)
				begin
					st_nxt.rx_busy = 1'b1;
					st_nxt.rx_idle = 1'b0;
					st_nxt.rcnt = 4'h0;
				end
			end
			else if (st_r.rcnt == nbits)
			begin
				st_nxt.rx_busy = 1'b0;
				st_nxt.rx_idle = 1'b1;
				st_nxt.rx_avail = 1'b1;
				word = st_r.rsh >> (4'h9 - nbits);
				st_nxt.rxd = word[7:0];
				if (cfg.nine_bit_select && !cfg.parity_enable)
					st_nxt.fc[FC_RX_NINTH] = word[8]; // R16 R10
				if (!cfg.nine_bit_select && cfg.parity_enable)
					st_nxt.rxd[7] = 1'b0; // R11
			end
			else
			begin
				st_nxt.rsh = {rx_level, st_r.rsh[8:1]};
				st_nxt.rcnt = st_r.rcnt + 4'h1;
			end
		end
		// Global disable overrides everything
		if (disable_now)
		begin
			st_nxt.sc[SC_TX_EN] = 1'b0; // R06
			st_nxt.sc[SC_RX_EN] = 1'b0;
			st_nxt.fc[FC_BREAK] = 1'b0;
			st_nxt.hold_full = 1'b0; // R05
			st_nxt.rx_avail = 1'b0;
			st_nxt.tx_idle = 1'b1;
			st_nxt.tx_empty = 1'b1;
			st_nxt.rx_idle = 1'b1;
			st_nxt.rx_busy = 1'b0; // R08
			st_nxt.txs = TX_IDLE;
			st_nxt.tx_line = 1'b1; // R07: fc except break, baud kept
		end
	end

	// State register
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			st_r <= '0;
			st_r.fc <= FRAME_CTRL_RST;
			st_r.sc <= SECOND_CTRL_RST;
			st_r.baud <= DIV_W'(BAUD_RST);
			st_r.tx_line <= 1'b1;
			st_r.tx_empty <= 1'b1;
			st_r.tx_idle <= 1'b1;
			st_r.rx_idle <= 1'b1;
			st_r.txs <= TX_IDLE;
		end
		else
			st_r <= st_nxt;
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign rdata = st_r.rdata;
	assign tx_out = st_r.tx_line;
	assign tx_oe = global_en && st_r.sc[SC_TX_EN]; // R04 R19
	assign rx_own = global_en && st_r.sc[SC_RX_EN]; // R04

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	property p_empty_on_load;
		@(posedge clk) disable iff (!rst_b)
		(st_r.txs == TX_IDLE && tx_oe && tick && st_r.hold_full && global_en)
		|=> st_r.tx_empty && st_r.txs == TX_START;
	endproperty
	a_empty_on_load: assert property (p_empty_on_load) // R01
		else $error("empty flag not set on load");

	property p_disable_flags;
		@(posedge clk) disable iff (!rst_b)
		!global_en |=> tx_out && st_r.tx_empty && st_r.tx_idle
			&& !st_r.sc[SC_TX_EN] && !st_r.fc[FC_BREAK];
	endproperty
	a_disable_flags: assert property (p_disable_flags) // R06
		else $error("disable did not reset flags");

	property p_pin_owner;
		@(posedge clk) disable iff (!rst_b)
		!global_en |-> !tx_oe && !rx_own;
	endproperty
	a_pin_owner: assert property (p_pin_owner) // R04
		else $error("pins held while disabled");

	property p_start_low;
		@(posedge clk) disable iff (!rst_b)
		$rose(st_r.txs == TX_START) |-> !tx_out;
	endproperty
	a_start_low: assert property (p_start_low) // R20
		else $error("start bit not low");

	property p_break_low;
		@(posedge clk) disable iff (!rst_b)
		st_r.txs == TX_BRK |-> !tx_out;
	endproperty
	a_break_low: assert property (p_break_low) // R15
		else $error("line high during break");

	property p_break_min;
		@(posedge clk) disable iff (!rst_b)
		($past(st_r.txs) == TX_BRK && st_r.txs == TX_IDLE && global_en)
		|-> $past(st_r.cnt) == BREAK_MIN_BITS;
	endproperty
	a_break_min: assert property (p_break_min) // R15
		else $error("break ended early");

	property p_idle_stop;
		@(posedge clk) disable iff (!rst_b)
		st_r.txs == TX_STOP |-> tx_out;
	endproperty
	a_idle_stop: assert property (p_idle_stop) // R14
		else $error("stop bit not high");

	property p_keep_cfg;
		@(posedge clk) disable iff (!rst_b)
		(!global_en && !wr) |=> st_r.baud == $past(st_r.baud)
			&& st_r.fc[6:3] == $past(st_r.fc[6:3]);
	endproperty
	a_keep_cfg: assert property (p_keep_cfg) // R07
		else $error("configuration lost on disable");
endmodule

// ===== bench/serial_peer.sv
/*
 Far-side serial peer: sends frames into the receive pin and
 captures frames from the transmit level.
 Assumes the bench passes the bit period in clocks.
*/
module serial_peer
(
	input wire logic clk, // System clock
	input wire logic tx_line, // Level from the unit
	output logic rx_line // Level into the unit
);
	timeunit 1ns;
	timeprecision 1ps;

	// Line idles high between frames
	initial rx_line = 1'b1;

	// Start bit, bits from index 0 up, then back to idle
	task automatic send(input logic [11:0] bits, input int n, input int p);
		@(posedge clk);
		rx_line <= 1'b0;
		repeat (p) @(posedge clk);
		for (int i = 0; i < n; i++)
		begin
			rx_line <= bits[i];
			repeat (p) @(posedge clk);
		end
		rx_line <= 1'b1;
	endtask

	// Waits for a start bit, then samples each bit mid-period
	task automatic grab(input int n, input int p, output logic [11:0] got,
		output bit ok);
		int w;
		got = 12'h000;
		ok = 1'b0;
		w = 0;
		while (tx_line !== 1'b0 && w < 4000)
		begin
			@(negedge clk);
			w++;
		end
		if (w < 4000)
		begin
			ok = 1'b1;
			repeat (p / 2) @(negedge clk);
			for (int i = 0; i < n; i++)
			begin
				repeat (p) @(negedge clk);
				got[i] = tx_line;
			end
		end
	endtask
endmodule

// ===== bench/uart_frame_control_bench.sv
/*
 Self-checking bench for the serial frame control block.
 Assumes the register map and reset values of the shared package.
*/
module uart_frame_control_bench
	import uart_frame_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int P = 8; // Bit period in clocks
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic [3:0] addr = 4'h0;
	logic [7:0] wdata = 8'h00;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [7:0] rdata;
	logic rx_pin;
	logic tx_out;
	logic tx_oe;
	logic rx_own;
	logic [11:0] got;
	bit ok;
	int err_total = 0;
	int cmp_count = 0;
	int n;
	int w;
	time t0;

	// ----------------------------------------
	// Clock, design and peer
	// ----------------------------------------
	always #2.5 clk = ~clk;

	uart_frame_control #(.DIV_W(8)) uut (.clk(clk), .rst_b(rst_b),
		.addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
		.rx_pin(rx_pin), .tx_out(tx_out), .tx_oe(tx_oe), .rx_own(rx_own));

	serial_peer peer (.clk(clk), .tx_line(tx_out), .rx_line(rx_pin));

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic chk(input logic [11:0] g, input logic [11:0] e);
		cmp_count++;
		if (g !== e)
		begin
			err_total++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask

	task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	// Read data is looked at in the cycle after the strobe
	task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		chk({4'h0, rdata}, {4'h0, e});
	endtask

	// Expected line bits; c holds nine, parity, odd, two-stop
	function automatic logic [11:0] frame_bits(input logic [8:0] d,
		input logic [3:0] c, output int cnt);
		logic [11:0] b;
		logic p;
		int k;
		cnt = 9 + c[3] + c[0];
		// Bits past the frame stay 0, as the peer leaves them
		b = 12'hFFF >> (12 - cnt);
		k = 8 + c[3] - c[2];
		p = c[1];
		for (int i = 0; i < k; i++)
		begin
			b[i] = d[i];
			p ^= d[i];
		end
		if (c[2])
			b[k] = p;
		return b;
	endfunction

	// One frame out, captured by the peer and checked, then idle status
	task automatic send_tx(input logic [3:0] c, input logic [8:0] d);
		logic [11:0] e;
		int cnt;
		e = frame_bits(d, c, cnt);
		wr_reg(ADDR_FRAME_CTRL, {1'b1, c, 2'b00, d[8]});
		rd_chk(ADDR_FRAME_CTRL, {1'b1, c, 3'b000});
		rd_chk(ADDR_STATUS, 8'h0B);
		wr_reg(ADDR_TX_HOLD, d[7:0]);
		peer.grab(cnt, P, got, ok);
		chk({11'h000, ok}, 12'h001);
		if (!ok)
			end_of_test();
		chk(got, e);
		repeat (P) @(posedge clk);
		rd_chk(ADDR_STATUS, 8'h0B);
	endtask

	// Bounded wait for a transmit level; a timeout ends the run
	task automatic wait_tx(input logic v, input int lim);
		w = 0;
		while (tx_out !== v && w < lim)
		begin
			@(negedge clk);
			w++;
		end
		if (w >= lim)
		begin
			err_total++;
			end_of_test();
		end
	endtask

	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial
	begin
		void'($urandom(32'h0655));
		repeat (10) @(posedge clk);
		rst_b <= 1'b1;
		// Reset values and an unmapped place
		rd_chk(ADDR_FRAME_CTRL, 8'h00);
		rd_chk(ADDR_SECOND_CTRL, 8'h00);
		rd_chk(ADDR_STATUS, 8'h0B);
		rd_chk(ADDR_BAUD, 8'h0F);
		wr_reg(4'h2, 8'hFF);
		rd_chk(4'h2, 8'h00);
		rd_chk(ADDR_FRAME_CTRL, 8'h00);
		$display("test reset done");
		// Pin ownership follows both enables
		wr_reg(ADDR_BAUD, 8'h07);
		wr_reg(ADDR_SECOND_CTRL, 8'hC0);
		rd_chk(ADDR_SECOND_CTRL, 8'h00);
		wr_reg(ADDR_FRAME_CTRL, 8'h80);
		@(negedge clk);
		chk({10'h000, tx_oe, rx_own}, 12'h000);
		wr_reg(ADDR_SECOND_CTRL, 8'h80);
		rd_chk(ADDR_STATUS, 8'h0B);
		chk({10'h000, tx_oe, rx_own}, 12'h002);
		wr_reg(ADDR_SECOND_CTRL, 8'hC0);
		@(negedge clk);
		chk({10'h000, tx_oe, rx_own}, 12'h003);
		// Held word waits while the transmitter is off
		wr_reg(ADDR_SECOND_CTRL, 8'h40);
		rd_chk(ADDR_STATUS, 8'h0B);
		wr_reg(ADDR_TX_HOLD, 8'h3C);
		rd_chk(ADDR_STATUS, 8'h08);
		wr_reg(ADDR_SECOND_CTRL, 8'hC0);
		repeat (16 * P) @(posedge clk);
		rd_chk(ADDR_STATUS, 8'h0B);
		$display("test enables done");
		// Every framing mode with random data, then corners
		for (int c = 0; c < 16; c++)
			send_tx(c[3:0], 9'($urandom));
		send_tx(4'hF, 9'h1FF);
		send_tx(4'h4, 9'h000);
		$display("test framing done");
		// Disable in mid-frame, then resume with kept settings
		wr_reg(ADDR_FRAME_CTRL, 8'hD8);
		wr_reg(ADDR_TX_HOLD, 8'hA5);
		repeat (3 * P) @(posedge clk);
		wr_reg(ADDR_FRAME_CTRL, 8'h5C);
		@(negedge clk);
		@(negedge clk);
		chk({9'h000, tx_oe, rx_own, tx_out}, 12'h001);
		rd_chk(ADDR_STATUS, 8'h0B);
		rd_chk(ADDR_SECOND_CTRL, 8'h00);
		rd_chk(ADDR_FRAME_CTRL, 8'h58);
		rd_chk(ADDR_BAUD, 8'h07);
		wr_reg(ADDR_FRAME_CTRL, 8'hD8);
		wr_reg(ADDR_SECOND_CTRL, 8'hC0);
		send_tx(4'hB, 9'h15A);
		$display("test disable done");
		// Break pulse still holds the line low for the minimum
		wr_reg(ADDR_FRAME_CTRL, 8'h84);
		wait_tx(1'b0, 100);
		t0 = $time;
		wr_reg(ADDR_FRAME_CTRL, 8'h80);
		wait_tx(1'b1, 1000);
		n = int'(($time - t0) / 5);
		chk({11'h000, n >= 13 * P && n < 16 * P}, 12'h001);
		$display("test break done");
		// Received ninth bit, then a parity frame that leaves it
		wr_reg(ADDR_FRAME_CTRL, 8'hC0);
		peer.send(12'h35A, 10, P);
		repeat (2 * P) @(posedge clk);
		rd_chk(ADDR_FRAME_CTRL, 8'hC2);
		rd_chk(ADDR_RX_DATA, 8'h5A);
		wr_reg(ADDR_FRAME_CTRL, 8'hE0);
		peer.send(12'h233, 10, P);
		repeat (2 * P) @(posedge clk);
		rd_chk(ADDR_FRAME_CTRL, 8'hE2);
		rd_chk(ADDR_RX_DATA, 8'h33);
		// Eight-bit parity frame: top data bit reads 0
		wr_reg(ADDR_FRAME_CTRL, 8'hA0);
		peer.send(12'h1FF, 9, P);
		repeat (2 * P) @(posedge clk);
		rd_chk(ADDR_RX_DATA, 8'h7F);
		$display("test receive done");
		end_of_test();
	end

	// Hang guard
	initial
	begin
		#200000;
		err_total++;
		end_of_test();
	end
endmodule
